// ===== pkg/tcc_pkg.sv
// constants and types of the timer counter control block
// assumes one kernel clock and a plain register port
package tcc_pkg;
   // ----------------------------------------
   // address map
   // ----------------------------------------
   localparam logic [31:0] TCC_BASE0    = 32'h4000_0000;
   localparam logic [31:0] TCC_STRIDE   = 32'h0000_0400;
   localparam logic [9:0]  TCC_OFF_CTL  = 10'h000;
   localparam logic [9:0]  TCC_OFF_STS  = 10'h004;
   localparam logic [9:0]  TCC_OFF_CNT  = 10'h008;
   localparam logic [9:0]  TCC_OFF_ARR  = 10'h00c;
   localparam logic [9:0]  TCC_OFF_CMP  = 10'h010;
   localparam logic [9:0]  TCC_OFF_CHM  = 10'h014;
   localparam logic [9:0]  TCC_OFF_EVG  = 10'h018;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int          TCC_CTL_W    = 10;
   localparam int          TCC_CEN      = 0;
   localparam int          TCC_UPDATE_SUPPRESS    = 1;
   localparam int          TCC_UPS      = 2;
   localparam int          TCC_SPM      = 3;
   localparam int          TCC_DIR      = 4;
   localparam int          TCC_CAM      = 5;
   localparam int          TCC_RELOAD_SHADOW_ENABLE     = 7;
   localparam int          TCC_SAMPLE_CLOCK_DIVIDER    = 8;
   localparam logic [9:0]  TCC_CTL_RST  = 10'h000;
   localparam int          TCC_STS_UPD  = 0;
   localparam int          TCC_STS_CH   = 1;
   localparam int          TCC_EVG_UG   = 0;
   localparam logic [1:0]  TCC_CHM_OUT  = 2'h0;
   localparam logic [1:0]  TCC_DIV_L1   = 2'h0;
   localparam logic [1:0]  TCC_DIV_L2   = 2'h1;
   localparam logic [1:0]  TCC_DIV_L4   = 2'h3;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TCC_CAM_EDGE = 2'h0,
      TCC_CAM_DOWN = 2'h1,
      TCC_CAM_UP   = 2'h2,
      TCC_CAM_BOTH = 2'h3
   } tcc_cam_t;
endpackage : tcc_pkg

// ===== pkg/tcc_ch_if.sv
// counter state handed to the compare channel
// assumes one kernel clock
`timescale 1ns/1ps
interface tcc_ch_if;
   import tcc_pkg::*;
   logic [15:0] cnt;
   logic [15:0] cmp;
   tcc_cam_t    alignment_mode_select;
   logic [1:0]  chm;
   logic        down;
   logic        run;
   logic        flag_set;
   modport ctl (output cnt, cmp, alignment_mode_select, chm, down, run, input flag_set);
   modport ch  (input cnt, cmp, alignment_mode_select, chm, down, run, output flag_set);
endinterface : tcc_ch_if

// ===== rtl/tcc_dts_div.sv
// sample clock tick divider
// assumes the kernel clock and synchronous reset
`timescale 1ns/1ps
module tcc_dts_div
   import tcc_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rstn_in,
   // control
   input  wire logic [1:0] sample_clock_divider_in,
   // tick
   output logic            tick_out
);
   logic [1:0] div_reg;
   logic [1:0] lim;
   logic       tick_reg;

   // ----------------------------------------
   // division
   // ----------------------------------------
   always_comb begin
      case (sample_clock_divider_in)
         2'h0:    lim = TCC_DIV_L1;
         2'h1:    lim = TCC_DIV_L2;
         default: lim = TCC_DIV_L4;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         div_reg  <= 2'h0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (div_reg >= lim);
         div_reg  <= (div_reg >= lim) ? 2'h0 : div_reg + 2'h1;
      end
   end

   assign tick_out = tick_reg;

   AST_DIV_HALF:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (sample_clock_divider_in == 2'h1 && $past(sample_clock_divider_in) == 2'h1 && tick_reg)
      |=> !tick_reg)
   else $error("half rate tick twice in a row");
endmodule : tcc_dts_div

// ===== rtl/tcc_chan.sv
// compare channel event flag source
// assumes counter state from the control block each cycle
`timescale 1ns/1ps
module tcc_chan
   import tcc_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys_in,
   input  wire logic rstn_in,
   // counter state
   tcc_ch_if.ch      ch
);
   logic gate;
   logic set_reg;

   // ----------------------------------------
   // direction gating
   // ----------------------------------------
   always_comb begin
      case (ch.alignment_mode_select)
         TCC_CAM_EDGE: gate = 1'b1;
         TCC_CAM_DOWN: gate = ch.down;
         TCC_CAM_UP:   gate = !ch.down;
         TCC_CAM_BOTH: gate = 1'b1;
         default:      gate = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         set_reg <= 1'b0;
      end else begin
         set_reg <= ch.run && ch.cnt == ch.cmp && gate
                    && (ch.chm == TCC_CHM_OUT || ch.alignment_mode_select == TCC_CAM_EDGE);
      end
   end

   assign ch.flag_set = set_reg;

   AST_CH_DOWN_ONLY:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (set_reg && $past(ch.alignment_mode_select) == TCC_CAM_DOWN) |-> $past(ch.down))
   else $error("flag set while counting up in down mode");

   AST_CH_UP_ONLY:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (set_reg && $past(ch.alignment_mode_select) == TCC_CAM_UP) |-> !$past(ch.down))
   else $error("flag set while counting down in up mode");
endmodule : tcc_chan

// ===== rtl/tcc_top.sv
// timer counter control with reload, compare channel and register port
// assumes a master that keeps strobes one cycle and never both at once
`timescale 1ns/1ps
module tcc_top
   import tcc_pkg::*;
#(
   parameter logic [1:0] INST_IDX = 2'h0
)
(
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // register port
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // slave mode restart trigger
   input  wire logic        restart_trig_in,
   // events
   output logic             update_event_out,
   output logic             update_req_out,
   output logic             chan_flag_out,
   output logic             sample_tick_out
);
   logic [31:0]          base;
   logic                 hit;
   logic [9:0]           off;
   logic [9:0]           ctl_reg;
   logic [9:0]           ctl_next;
   logic [15:0]          arr_reg;
   logic [15:0]          arr_sh_reg;
   logic [15:0]          cmp_reg;
   logic [1:0]           chm_reg;
   logic [15:0]          cnt_reg;
   logic [15:0]          cnt_next;
   logic [1:0]           sts_reg;
   logic [1:0]           sts_set;
   logic [31:0]          rdata_reg;
   logic [31:0]          rd_val;
   logic                 upd_evt_reg;
   logic                 upd_req_reg;
   logic                 wr_ctl;
   logic                 wr_arr;
   logic                 ug;
   logic                 reinit;
   logic                 ovf;
   logic                 udf;
   logic                 uev;
   logic                 counter_run_enable;
   logic                 down;
   tcc_cam_t             alignment_mode_select;
   tcc_cam_t             cam_new;

   tcc_ch_if ch_bus ();

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   assign base   = TCC_BASE0 + TCC_STRIDE * {30'h0, INST_IDX};
   assign hit    = addr_in[31:10] == base[31:10];
   assign off    = addr_in[9:0];
   assign wr_ctl = wr_in && hit && off == TCC_OFF_CTL;
   assign wr_arr = wr_in && hit && off == TCC_OFF_ARR;
   assign ug     = wr_in && hit && off == TCC_OFF_EVG
                   && wdata_in[TCC_EVG_UG];
   assign reinit = ug || restart_trig_in;
   assign counter_run_enable    = ctl_reg[TCC_CEN];
   assign down   = ctl_reg[TCC_DIR];
   assign alignment_mode_select    = tcc_cam_t'(ctl_reg[TCC_CAM +: 2]);
   assign cam_new = tcc_cam_t'(wdata_in[TCC_CAM +: 2]);

   // ----------------------------------------
   // counter step
   // ----------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      ovf      = 1'b0;
      udf      = 1'b0;
      if (reinit) begin
         cnt_next = (alignment_mode_select == TCC_CAM_EDGE && down) ? arr_sh_reg : 16'h0;
      end else if (counter_run_enable) begin
         if (alignment_mode_select == TCC_CAM_EDGE) begin
            if (!down) begin
               ovf      = cnt_reg >= arr_sh_reg;
               cnt_next = ovf ? 16'h0 : cnt_reg + 16'h1;
            end else begin
               udf      = cnt_reg == 16'h0;
               cnt_next = udf ? arr_sh_reg : cnt_reg - 16'h1;
            end
         end else if (!down) begin
            ovf      = cnt_reg >= arr_sh_reg;
            cnt_next = ovf ? ((arr_sh_reg == 16'h0) ? 16'h0
                                                    : arr_sh_reg - 16'h1)
                           : cnt_reg + 16'h1;
         end else begin
            udf      = cnt_reg == 16'h0;
            cnt_next = udf ? ((arr_sh_reg == 16'h0) ? 16'h0 : 16'h1)
                           : cnt_reg - 16'h1;
         end
      end
   end

   // update event and its request
   assign uev = !ctl_reg[TCC_UPDATE_SUPPRESS] && (ovf || udf || reinit);

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         cnt_reg <= 16'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next = wdata_in[TCC_CTL_W-1:0];
         if (counter_run_enable && alignment_mode_select == TCC_CAM_EDGE && cam_new != TCC_CAM_EDGE) begin
            ctl_next[TCC_CAM +: 2] = ctl_reg[TCC_CAM +: 2];
         end
         if (ctl_next[TCC_CAM +: 2] != TCC_CAM_EDGE
             || alignment_mode_select != TCC_CAM_EDGE) begin
            ctl_next[TCC_DIR] = ctl_reg[TCC_DIR];
         end
      end
      if (alignment_mode_select != TCC_CAM_EDGE && !reinit && (ovf || udf)) begin
         ctl_next[TCC_DIR] = ovf;
      end
      if (ctl_reg[TCC_SPM] && (ovf || udf)) begin
         ctl_next[TCC_CEN] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         ctl_reg <= TCC_CTL_RST;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // ----------------------------------------
   // reload, compare and channel mode
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         arr_reg    <= 16'h0;
         arr_sh_reg <= 16'h0;
      end else begin
         if (wr_arr) begin
            arr_reg <= wdata_in[15:0];
         end
         if (wr_arr && !ctl_reg[TCC_RELOAD_SHADOW_ENABLE]) begin
            arr_sh_reg <= wdata_in[15:0];
         end else if (uev) begin
            arr_sh_reg <= arr_reg;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         cmp_reg <= 16'h0;
         chm_reg <= 2'h0;
      end else begin
         if (wr_in && hit && off == TCC_OFF_CMP) begin
            cmp_reg <= wdata_in[15:0];
         end
         if (wr_in && hit && off == TCC_OFF_CHM) begin
            chm_reg <= wdata_in[1:0];
         end
      end
   end

   // ----------------------------------------
   // update outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         upd_evt_reg <= 1'b0;
         upd_req_reg <= 1'b0;
      end else begin
         upd_evt_reg <= uev;
         upd_req_reg <= uev && (!ctl_reg[TCC_UPS] || ovf || udf);
      end
   end

   // ----------------------------------------
   // sticky status, set wins over clear
   // ----------------------------------------
   assign sts_set = {ch_bus.flag_set, upd_req_reg};

   for (genvar i = 0; i < 2; i++) begin : g_sts
      always_ff @(posedge clk_sys_in) begin
         if (!rstn_in) begin
            sts_reg[i] <= 1'b0;
         end else if (sts_set[i]) begin
            sts_reg[i] <= 1'b1;
         end else if (wr_in && hit && off == TCC_OFF_STS
                      && !wdata_in[i]) begin
            sts_reg[i] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb begin
      rd_val = 32'h0;
      case (off)
         TCC_OFF_CTL: rd_val = {22'h0, ctl_reg};
         TCC_OFF_STS: rd_val = {30'h0, sts_reg};
         TCC_OFF_CNT: rd_val = {16'h0, cnt_reg};
         TCC_OFF_ARR: rd_val = {16'h0, arr_reg};
         TCC_OFF_CMP: rd_val = {16'h0, cmp_reg};
         TCC_OFF_CHM: rd_val = {30'h0, chm_reg};
         default:     rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= (rd_in && hit) ? rd_val : 32'h0;
      end
   end

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   assign ch_bus.cnt  = cnt_reg;
   assign ch_bus.cmp  = cmp_reg;
   assign ch_bus.alignment_mode_select  = alignment_mode_select;
   assign ch_bus.chm  = chm_reg;
   assign ch_bus.down = down;
   assign ch_bus.run  = counter_run_enable;

   tcc_chan u_chan (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .ch         (ch_bus.ch)
   );

   tcc_dts_div u_div (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .sample_clock_divider_in   (ctl_reg[TCC_SAMPLE_CLOCK_DIVIDER +: 2]),
      .tick_out   (sample_tick_out)
   );

   assign rdata_out        = rdata_reg;
   assign update_event_out = upd_evt_reg;
   assign update_req_out   = upd_req_reg;
   assign chan_flag_out    = sts_reg[TCC_STS_CH];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_ARR_DIRECT:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_arr && !ctl_reg[TCC_RELOAD_SHADOW_ENABLE]) |=> arr_sh_reg == $past(wdata_in[15:0]))
   else $error("direct reload not applied");

   AST_ARR_SHADOW:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_arr && ctl_reg[TCC_RELOAD_SHADOW_ENABLE] && !uev) |=> $stable(arr_sh_reg))
   else $error("shadowed reload changed without update");

   AST_CAM_LOCK:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_ctl && counter_run_enable && alignment_mode_select == TCC_CAM_EDGE) |=> alignment_mode_select == TCC_CAM_EDGE)
   else $error("alignment left edge mode while running");

   AST_DIR_RO:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_ctl && !counter_run_enable && alignment_mode_select != TCC_CAM_EDGE) |=> $stable(down))
   else $error("direction written in centre mode");

   AST_SPM_STOP:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (ctl_reg[TCC_SPM] && (ovf || udf) && !wr_ctl) |=> !counter_run_enable)
   else $error("single pulse did not stop");

   AST_UPS_ONLY_WRAP:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (ctl_reg[TCC_UPS] && !ovf && !udf) |=> !upd_req_reg)
   else $error("update request without wrap");

   AST_UPDATE_SUPPRESS:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (ctl_reg[TCC_UPDATE_SUPPRESS] && reinit && !down)
      |=> !upd_evt_reg && cnt_reg == 16'h0)
   else $error("suppressed update misbehaved");

   AST_EDGE_WRAP:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (counter_run_enable && alignment_mode_select == TCC_CAM_EDGE && !down && !reinit
       && cnt_reg == arr_sh_reg) |=> cnt_reg == 16'h0 ##0 upd_req_reg
       || $past(ctl_reg[TCC_UPDATE_SUPPRESS]))
   else $error("edge up count did not wrap");

   AST_READ_ONE:
   assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !$past(rd_in) |-> rdata_reg == 32'h0)
   else $error("read data outside read cycle");
endmodule : tcc_top

// ===== verif/timer_counter_control_test.sv
// self-checking bench of the timer counter control top
// assumes the register port of tcc_top and instance index 2
`timescale 1ns/1ps
module timer_counter_control_test;
   import tcc_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam logic [31:0] BASE = TCC_BASE0 + 32'h0000_0800;
   logic        clk_sys_in;
   logic        rstn_in;
   logic [31:0] addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   logic        restart_trig_in;
   logic        update_event_out;
   logic        update_req_out;
   logic        chan_flag_out;
   logic        sample_tick_out;
   int          mismatches;
   int          checks;
   int          n;
   int          e;
   int          r;
   logic [31:0] v;

   tcc_top #(.INST_IDX(2'h2)) i_dut (
      .clk_sys_in      (clk_sys_in),
      .rstn_in         (rstn_in),
      .addr_in         (addr_in),
      .wdata_in        (wdata_in),
      .wr_in           (wr_in),
      .rd_in           (rd_in),
      .rdata_out       (rdata_out),
      .restart_trig_in (restart_trig_in),
      .update_event_out(update_event_out),
      .update_req_out  (update_req_out),
      .chan_flag_out   (chan_flag_out),
      .sample_tick_out (sample_tick_out)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, exp);
      checks++;
      if (s !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, s);
      end
   endtask : chk

   task automatic wr_abs(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      wr_in    <= 1'b0;
   endtask : wr_abs

   task automatic wr(input logic [9:0] o, input logic [31:0] d);
      wr_abs(BASE + {22'h0, o}, d);
   endtask : wr

   task automatic rd(input logic [9:0] o, output logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= BASE + {22'h0, o};
      rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      rd_in   <= 1'b0;
      #1;
      d = rdata_out;
   endtask : rd

   task automatic restart();
      @(posedge clk_sys_in);
      restart_trig_in <= 1'b1;
      @(posedge clk_sys_in);
      restart_trig_in <= 1'b0;
   endtask : restart

   task automatic watch(input int c, output int ev, output int rq);
      ev = 0;
      rq = 0;
      // first look falls in the cycle opened by the caller's last edge
      repeat (c) begin
         #1;
         if (update_event_out === 1'b1) ev++;
         if (update_req_out === 1'b1) rq++;
         @(posedge clk_sys_in);
      end
   endtask : watch

   task automatic wait_ev(output int c);
      c = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         c++;
      end while (update_event_out !== 1'b1 && c < 60);
   endtask : wait_ev

   // stop, leave centre mode, clear direction, reinitialise, clear status
   task automatic park();
      wr(TCC_OFF_CTL, 32'h0);
      wr(TCC_OFF_CTL, 32'h0);
      wr(TCC_OFF_EVG, 32'h1);
      wr(TCC_OFF_STS, 32'h0);
   endtask : park

   task automatic give_verdict();
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_map();
      rd(TCC_OFF_CTL, v);
      chk("ctl_reset", v, 32'h0);
      rd(TCC_OFF_EVG, v);
      chk("evg_read", v, 32'h0);
      rd(10'h01c, v);
      chk("unmapped", v, 32'h0);
      wr_abs(TCC_BASE0, 32'h80);
      rd(TCC_OFF_CTL, v);
      chk("other_base", v, 32'h0);
      wr(TCC_OFF_CTL, 32'h29e);
      rd(TCC_OFF_CTL, v);
      chk("ctl_rw", v, 32'h29e);
   endtask : t_map

   task automatic t_edge();
      park();
      wr(TCC_OFF_ARR, 32'h3);
      wr(TCC_OFF_CTL, 32'h1);
      wait_ev(n);
      wait_ev(n);
      chk("up_period", 32'(n), 32'h4);
      chk("wrap_req", {31'h0, update_req_out}, 32'h1);
      wr(TCC_OFF_ARR, 32'h5);
      wait_ev(n);
      wait_ev(n);
      chk("direct_reload", 32'(n), 32'h6);
   endtask : t_edge

   task automatic t_shadow();
      park();
      wr(TCC_OFF_CTL, 32'h80);
      wr(TCC_OFF_ARR, 32'h2);
      wr(TCC_OFF_CTL, 32'h81);
      wait_ev(n);
      chk("old_shadow", 32'(n >= 5), 32'h1);
      wait_ev(n);
      chk("new_shadow", 32'(n), 32'h3);
   endtask : t_shadow

   task automatic t_down();
      park();
      wr(TCC_OFF_ARR, 32'h3);
      wr(TCC_OFF_CTL, 32'h10);
      rd(TCC_OFF_CTL, v);
      chk("dir_rw", v, 32'h10);
      wr(TCC_OFF_CTL, 32'h11);
      wait_ev(n);
      wait_ev(n);
      chk("down_period", 32'(n), 32'h4);
   endtask : t_down

   task automatic t_source();
      park();
      wr(TCC_OFF_EVG, 32'h1);
      watch(4, e, r);
      chk("ug_event", 32'(e), 32'h1);
      chk("ug_req", 32'(r), 32'h1);
      rd(TCC_OFF_STS, v);
      chk("sts_upd", v, 32'h1);
      restart();
      watch(4, e, r);
      chk("trig_req", 32'(r), 32'h1);
      wr(TCC_OFF_CTL, 32'h4);
      wr(TCC_OFF_EVG, 32'h1);
      watch(4, e, r);
      chk("ups_event", 32'(e), 32'h1);
      chk("ups_req", 32'(r), 32'h0);
      wr(TCC_OFF_ARR, 32'h3);
      wr(TCC_OFF_CTL, 32'h5);
      wait_ev(n);
      watch(8, e, r);
      chk("ups_wrap_req", 32'(r), 32'h2);
   endtask : t_source

   task automatic t_suppress();
      park();
      wr(TCC_OFF_ARR, 32'h3);
      wr(TCC_OFF_CTL, 32'h3);
      watch(9, e, r);
      chk("sup_wrap", 32'(e + r), 32'h0);
      wr(TCC_OFF_CTL, 32'h2);
      restart();
      watch(3, e, r);
      chk("sup_trig", 32'(e + r), 32'h0);
      rd(TCC_OFF_CNT, v);
      chk("sup_reinit", v, 32'h0);
   endtask : t_suppress

   task automatic t_single();
      park();
      wr(TCC_OFF_ARR, 32'h3);
      wr(TCC_OFF_CTL, 32'h9);
      watch(12, e, r);
      chk("spm_events", 32'(e), 32'h1);
      rd(TCC_OFF_CTL, v);
      chk("spm_stop", v, 32'h8);
   endtask : t_single

   task automatic t_lock();
      park();
      wr(TCC_OFF_CTL, 32'h1);
      wr(TCC_OFF_CTL, 32'h21);
      rd(TCC_OFF_CTL, v);
      chk("cam_lock", v, 32'h1);
      park();
      wr(TCC_OFF_CTL, 32'h20);
      wr(TCC_OFF_CTL, 32'h30);
      rd(TCC_OFF_CTL, v);
      chk("dir_ro", v, 32'h20);
   endtask : t_lock

   task automatic t_tick();
      for (int c = 0; c < 3; c++) begin
         wr(TCC_OFF_CTL, {22'h0, 2'(c), 8'h0});
         watch(2, e, r);
         n = 0;
         repeat (16) begin
            @(posedge clk_sys_in);
            #1;
            if (sample_tick_out === 1'b1) n++;
         end
         chk("tick_count", 32'(n), 32'(16 >> c));
      end
   endtask : t_tick

   task automatic t_centre(input logic [1:0] alignment_mode_select);
      park();
      wr(TCC_OFF_ARR, 32'h4);
      wr(TCC_OFF_CMP, 32'h2);
      wr(TCC_OFF_CHM, 32'h0);
      wr(TCC_OFF_STS, 32'h0);
      wr(TCC_OFF_CTL, {25'h0, alignment_mode_select, 5'h0});
      wr(TCC_OFF_CTL, {25'h0, alignment_mode_select, 5'h1});
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end while (chan_flag_out !== 1'b1 && n < 20);
      chk("flag_set", {31'h0, chan_flag_out}, 32'h1);
      chk("flag_early", 32'(n <= 4), 32'(alignment_mode_select != 2'h1));
      if (alignment_mode_select == 2'h3) begin
         wait_ev(n);
         wait_ev(n);
         chk("centre_half", 32'(n), 32'h4);
      end
   endtask : t_centre
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      mismatches      = 0;
      checks          = 0;
      rstn_in         = 1'b0;
      addr_in         = 32'h0;
      wdata_in        = 32'h0;
      wr_in           = 1'b0;
      rd_in           = 1'b0;
      restart_trig_in = 1'b0;
      repeat (8) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      t_map();
      t_edge();
      t_shadow();
      t_down();
      t_source();
      t_suppress();
      t_single();
      t_lock();
      t_tick();
      for (int c = 0; c < 4; c++) begin
         t_centre(2'(c));
      end
      give_verdict();
   end

   initial begin
      #(100 * 30000);
      mismatches++;
      give_verdict();
   end
endmodule : timer_counter_control_test
